// [verilog/timer_capture_compare_pwm.sv]
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "tccp_params.svh"
// Behaviour
// - First timer counts only while enabled
// - Clock source: pin edges or osc over four
// - Optional sync of pin clock to oscillator
// - Control bit enables crystal oscillator circuit
// - First timer prescale one, two, four, eight
// - First timer count readable and loadable
// - Second timer prescale one, four, sixteen
// - Second timer counts only while enabled
// - Postscale divisor is field plus one
// - Second timer count and period accessible
// - Unit modes: off, capture, compare, PWM
// - Low mode bits pick mode variant
// - Control bits five, four: duty low bits
// - Compare value matched against first timer
// - Capture stores first timer count
// - Value low byte: duty high bits
// - Second unit identical to first
// - PWM uses second timer, drives pin
// - Compare match raises event flag
// - Capture latches count on pin edge
// - Flags: overflow, second timer, unit events
module timer_capture_compare_pwm
  import tccp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // AXI4-Lite write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Counting pin and oscillator
  input wire logic external_count_pin,
  output logic osc_circuit_enable,
  // Unit pins
  input wire logic unit_one_pin_in,
  output logic unit_one_pin_out,
  output logic unit_one_pin_oe,
  input wire logic unit_two_pin_in,
  output logic unit_two_pin_out,
  output logic unit_two_pin_oe,
  // Sticky event flags
  output logic [3:0] event_flags
);
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic aw_got_q, w_got_q;
  logic [1:0] bresp_q, rresp_q;
  logic [7:0] aw_addr_q;
  logic [31:0] wdata_q, wmask_q, rdata_q, rd_data;
  logic aw_take, w_take, ar_take, wr_go, wr_err, rd_err;
  logic aw_got_d, w_got_d, bvalid_d, rvalid_d;
  logic wsel_t1c, wsel_t1n, wsel_t2c, wsel_t2n, wsel_t2p;
  logic wsel_u1c, wsel_u1v, wsel_u2c, wsel_u2v, wsel_flg;
  logic [5:0] t1_ctrl_q, u1_ctrl_q, u2_ctrl_q;
  logic [6:0] t2_ctrl_q;
  logic [7:0] t2_period_q, t2_count_q;
  logic [15:0] t1_count_q, u1_value, u2_value;
  logic [2:0] pin_s1_q, pin_s2_q;
  logic ext_prev_q, ext_pend_q, ext_rise, osc_tick, t1_src, t1_step, t1_ovf;
  logic [1:0] osc_div_q, t2_frac;
  logic [2:0] t1_pre_q, t1_pmask;
  logic [3:0] t2_pre_q, t2_pmask, t2_post_q, flags_q, flag_set;
  logic t2_step, t2_restart, t2_event, u1_event, u2_event, t2_adv;
  logic [9:0] t2_fine;

  // Channel handshakes
  assign aw_take = s_axi_awvalid && awready_q;
  assign w_take = s_axi_wvalid && wready_q;
  assign ar_take = s_axi_arvalid && arready_q;
  assign wr_go = aw_got_q && w_got_q;
  assign aw_got_d = (aw_got_q || aw_take) && !wr_go;
  assign w_got_d = (w_got_q || w_take) && !wr_go;
  assign bvalid_d = wr_go || (bvalid_q && !s_axi_bready);
  assign rvalid_d = ar_take || (rvalid_q && !s_axi_rready);

  // Write side state
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      bvalid_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
    end else begin
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      bvalid_q <= bvalid_d;
      awready_q <= !aw_got_d && !bvalid_d;
      wready_q <= !w_got_d && !bvalid_d;
      if (wr_go) bresp_q <= wr_err ? `RESP_SLVERR : `RESP_OKAY;
    end
  end

  // Write payload capture
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_addr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wmask_q <= 32'h0000_0000;
    end else begin
      if (aw_take) aw_addr_q <= s_axi_awaddr;
      if (w_take) begin
        wdata_q <= s_axi_wdata;
        wmask_q <= lane_mask(s_axi_wstrb);
      end
    end
  end

  // Write address decode
  always_comb begin
    wsel_t1c = 1'b0;
    wsel_t1n = 1'b0;
    wsel_t2c = 1'b0;
    wsel_t2n = 1'b0;
    wsel_t2p = 1'b0;
    wsel_u1c = 1'b0;
    wsel_u1v = 1'b0;
    wsel_u2c = 1'b0;
    wsel_u2v = 1'b0;
    wsel_flg = 1'b0;
    wr_err = 1'b0;
    if (aw_addr_q == `T1_CTRL_OFS) wsel_t1c = wr_go;
    else if (aw_addr_q == `T1_COUNT_OFS) wsel_t1n = wr_go;
    else if (aw_addr_q == `T2_CTRL_OFS) wsel_t2c = wr_go;
    else if (aw_addr_q == `T2_COUNT_OFS) wsel_t2n = wr_go;
    else if (aw_addr_q == `T2_PERIOD_OFS) wsel_t2p = wr_go;
    else if (aw_addr_q == `U1_CTRL_OFS) wsel_u1c = wr_go;
    else if (aw_addr_q == `U1_VALUE_OFS) wsel_u1v = wr_go;
    else if (aw_addr_q == `U2_CTRL_OFS) wsel_u2c = wr_go;
    else if (aw_addr_q == `U2_VALUE_OFS) wsel_u2v = wr_go;
    else if (aw_addr_q == `FLAGS_OFS) wsel_flg = wr_go;
    else wr_err = 1'b1;
  end

  // Control and period registers, byte-lane merged
  always_ff @(posedge clk) begin
    if (rst) begin
      t1_ctrl_q <= 6'(`CTRL_RST);
      t2_ctrl_q <= 7'(`CTRL_RST);
      t2_period_q <= `PERIOD_RST;
      u1_ctrl_q <= 6'(`CTRL_RST);
      u2_ctrl_q <= 6'(`CTRL_RST);
    end else begin
      if (wsel_t1c) t1_ctrl_q <= (t1_ctrl_q & ~wmask_q[5:0]) | (wdata_q[5:0] & wmask_q[5:0]);
      if (wsel_t2c) t2_ctrl_q <= (t2_ctrl_q & ~wmask_q[6:0]) | (wdata_q[6:0] & wmask_q[6:0]);
      if (wsel_t2p) t2_period_q <= wmask_q[0] ? wdata_q[7:0] : t2_period_q;
      if (wsel_u1c) u1_ctrl_q <= (u1_ctrl_q & ~wmask_q[5:0]) | (wdata_q[5:0] & wmask_q[5:0]);
      if (wsel_u2c) u2_ctrl_q <= (u2_ctrl_q & ~wmask_q[5:0]) | (wdata_q[5:0] & wmask_q[5:0]);
    end
  end

  // Read decode
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err = 1'b0;
    if (s_axi_araddr == `T1_CTRL_OFS) rd_data = {26'h0, t1_ctrl_q};
    else if (s_axi_araddr == `T1_COUNT_OFS) rd_data = {16'h0000, t1_count_q};
    else if (s_axi_araddr == `T2_CTRL_OFS) rd_data = {25'h0, t2_ctrl_q};
    else if (s_axi_araddr == `T2_COUNT_OFS) rd_data = {24'h00_0000, t2_count_q};
    else if (s_axi_araddr == `T2_PERIOD_OFS) rd_data = {24'h00_0000, t2_period_q};
    else if (s_axi_araddr == `U1_CTRL_OFS) rd_data = {26'h0, u1_ctrl_q};
    else if (s_axi_araddr == `U1_VALUE_OFS) rd_data = {16'h0000, u1_value};
    else if (s_axi_araddr == `U2_CTRL_OFS) rd_data = {26'h0, u2_ctrl_q};
    else if (s_axi_araddr == `U2_VALUE_OFS) rd_data = {16'h0000, u2_value};
    else if (s_axi_araddr == `FLAGS_OFS) rd_data = {28'h000_0000, flags_q};
    else rd_err = 1'b1;
  end

  // Read side state
  always_ff @(posedge clk) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `RESP_OKAY;
    end else begin
      rvalid_q <= rvalid_d;
      arready_q <= !rvalid_d;
      if (ar_take) begin
        rdata_q <= rd_data;
        rresp_q <= rd_err ? `RESP_SLVERR : `RESP_OKAY;
      end
    end
  end

  // Pin synchronisers
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
    end else begin
      pin_s1_q <= {unit_two_pin_in, unit_one_pin_in, external_count_pin};
      pin_s2_q <= pin_s1_q;
    end
  end

  // Instruction clock divider and pin edge tracking
  always_ff @(posedge clk) begin
    if (rst) begin
      osc_div_q <= 2'h0;
      ext_prev_q <= 1'b0;
      ext_pend_q <= 1'b0;
    end else begin
      osc_div_q <= osc_div_q + 2'h1;
      ext_prev_q <= pin_s2_q[0];
      if (osc_tick) ext_pend_q <= 1'b0;
      else if (ext_rise) ext_pend_q <= 1'b1;
    end
  end

  // First timer clock selection and prescale
  assign osc_tick = (osc_div_q == `OSC_DIV_LAST);
  assign ext_rise = pin_s2_q[0] && !ext_prev_q;
  always_comb begin
    if (!t1_ctrl_q[`T1_EXT_BIT]) t1_src = osc_tick;
    else if (t1_ctrl_q[`T1_SYNC_BIT]) t1_src = osc_tick && (ext_pend_q || ext_rise);
    else t1_src = ext_rise;
  end
  assign t1_pmask = {t1_ctrl_q[5:4] == 2'h3, t1_ctrl_q[5], t1_ctrl_q[5:4] != 2'h0};
  assign t1_step = t1_ctrl_q[`T1_ON_BIT] && t1_src && ((t1_pre_q & t1_pmask) == t1_pmask);
  assign t1_ovf = t1_step && (t1_count_q == 16'hFFFF) && !wsel_t1n;
  assign osc_circuit_enable = t1_ctrl_q[`T1_OSC_BIT];

  // First timer count; a software load wins over counting
  always_ff @(posedge clk) begin
    if (rst) begin
      t1_count_q <= `COUNT_RST;
      t1_pre_q <= 3'h0;
    end else if (wsel_t1n) begin
      t1_count_q <= (t1_count_q & ~wmask_q[15:0]) | (wdata_q[15:0] & wmask_q[15:0]);
      t1_pre_q <= 3'h0;
    end else if (t1_ctrl_q[`T1_ON_BIT] && t1_src) begin
      t1_pre_q <= t1_pre_q + 3'h1;
      if (t1_step) t1_count_q <= t1_count_q + 16'h0001;
    end
  end

  // Second timer prescale, period match and postscale
  assign t2_pmask = t2_ctrl_q[1] ? 4'hF : (t2_ctrl_q[0] ? 4'h3 : 4'h0);
  assign t2_step = t2_ctrl_q[`T2_ON_BIT] && osc_tick && ((t2_pre_q & t2_pmask) == t2_pmask);
  assign t2_restart = t2_step && (t2_count_q == t2_period_q) && !wsel_t2n;
  assign t2_event = t2_restart && (t2_post_q == t2_ctrl_q[`T2_POST_LO +: 4]);
  assign t2_frac = t2_ctrl_q[1] ? t2_pre_q[3:2] : (t2_ctrl_q[0] ? t2_pre_q[1:0] : osc_div_q);
  // Fine count as it stands after this edge, so the registered pin falls on time
  assign t2_adv = (t2_pmask == 4'h0) || (t2_ctrl_q[`T2_ON_BIT] && osc_tick);
  assign t2_fine = {t2_count_q, t2_frac} + {9'h000, t2_adv};
  always_ff @(posedge clk) begin
    if (rst) begin
      t2_count_q <= 8'h00;
      t2_pre_q <= 4'h0;
      t2_post_q <= 4'h0;
    end else begin
      if (wsel_t2n) begin
        t2_count_q <= wmask_q[0] ? wdata_q[7:0] : t2_count_q;
        t2_pre_q <= 4'h0;
      end else if (t2_ctrl_q[`T2_ON_BIT] && osc_tick) begin
        t2_pre_q <= t2_pre_q + 4'h1;
        if (t2_restart) t2_count_q <= 8'h00;
        else if (t2_step) t2_count_q <= t2_count_q + 8'h01;
      end
      if (t2_event) t2_post_q <= 4'h0;
      else if (t2_restart) t2_post_q <= t2_post_q + 4'h1;
    end
  end

  // Sticky flags; a new event wins over a write-one clear
  assign flag_set = {u2_event, u1_event, t2_event, t1_ovf};
  always_ff @(posedge clk) begin
    if (rst) flags_q <= 4'h0;
    else if (wsel_flg) flags_q <= (flags_q & ~(wdata_q[3:0] & wmask_q[3:0])) | flag_set;
    else flags_q <= flags_q | flag_set;
  end

  // First capture/compare unit
  capcomp_unit #(.TW(16)) unit_one (
    .clk(clk),
    .rst(rst),
    .ctrl(u1_ctrl_q),
    .value_wr(wsel_u1v),
    .value_wdata(wdata_q[15:0]),
    .value_wmask(wmask_q[15:0]),
    .value_q(u1_value),
    .t1_count(t1_count_q),
    .t2_restart(t2_restart),
    .t2_fine(t2_fine),
    .pin_sync(pin_s2_q[1]),
    .pin_out_q(unit_one_pin_out),
    .pin_oe_q(unit_one_pin_oe),
    .event_q(u1_event)
  );

  // Second unit, same logic as the first
  capcomp_unit #(.TW(16)) unit_two (
    .clk(clk),
    .rst(rst),
    .ctrl(u2_ctrl_q),
    .value_wr(wsel_u2v),
    .value_wdata(wdata_q[15:0]),
    .value_wmask(wmask_q[15:0]),
    .value_q(u2_value),
    .t1_count(t1_count_q),
    .t2_restart(t2_restart),
    .t2_fine(t2_fine),
    .pin_sync(pin_s2_q[2]),
    .pin_out_q(unit_two_pin_out),
    .pin_oe_q(unit_two_pin_oe),
    .event_q(u2_event)
  );

  // Bus outputs from flops
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign event_flags = flags_q;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_int_run;
    t1_ctrl_q[1:0] == 2'h1 && t1_ctrl_q[5:4] == 2'h0 && !wsel_t1n && !wsel_t1c;
  endsequence
  sequence s_t2_match;
    t2_restart;
  endsequence
  chk_t1_hold: assert property (!t1_ctrl_q[`T1_ON_BIT] && !wsel_t1n |=> $stable(t1_count_q))
    else $error("first timer moved while disabled");
  chk_osc_quarter: assert property (s_int_run [*4] |=> t1_count_q == 16'($past(t1_count_q, 4) + 16'h0001))
    else $error("internal clock not one count per four cycles");
  chk_t1_wrap: assert property (t1_ovf |=> t1_count_q == 16'h0000 && flags_q[0])
    else $error("first timer did not wrap with overflow flag");
  chk_t2_restart: assert property (s_t2_match |=> t2_count_q == 8'h00)
    else $error("second timer not cleared after period match");
  chk_flag_sticky: assert property (flags_q[1] && !(wsel_flg && wdata_q[1] && wmask_q[1]) |=> flags_q[1])
    else $error("event flag lost without clear");
endmodule // timer_capture_compare_pwm

// [verilog/tccp_params.svh]
`ifndef TCCP_PARAMS_SVH
`define TCCP_PARAMS_SVH
// Register byte offsets
`define T1_CTRL_OFS 8'h00
`define T1_COUNT_OFS 8'h04
`define T2_CTRL_OFS 8'h08
`define T2_COUNT_OFS 8'h0C
`define T2_PERIOD_OFS 8'h10
`define U1_CTRL_OFS 8'h14
`define U1_VALUE_OFS 8'h18
`define U2_CTRL_OFS 8'h1C
`define U2_VALUE_OFS 8'h20
`define FLAGS_OFS 8'h24
// First timer control fields
`define T1_ON_BIT 0
`define T1_EXT_BIT 1
`define T1_SYNC_BIT 2
`define T1_OSC_BIT 3
`define T1_PS_LO 4
// Second timer control fields
`define T2_PS_LO 0
`define T2_ON_BIT 2
`define T2_POST_LO 3
// Unit control fields
`define U_MODE_LO 0
`define U_DUTY_LO 4
// Flag positions
`define FLAG_T1_OVF 0
`define FLAG_T2_EVT 1
`define FLAG_U1_EVT 2
`define FLAG_U2_EVT 3
// Reset values
`define CTRL_RST 8'h00
`define COUNT_RST 16'h0000
`define PERIOD_RST 8'hFF
// Core clock divider for the instruction clock
`define OSC_DIV_LAST 2'h3
// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// [verilog/tccp_pkg.sv]
package tccp_pkg;
  typedef enum {unit_off, unit_capture, unit_compare, unit_pwm} unit_mode_t;

  // Mode from the four mode bits; 00xx other than 0000 is treated as off
  function automatic unit_mode_t decode_mode(input logic [3:0] m);
    case (m[3:2])
      2'h1: decode_mode = unit_capture;
      2'h2: decode_mode = unit_compare;
      2'h3: decode_mode = unit_pwm;
      default: decode_mode = unit_off;
    endcase
  endfunction

  // Byte strobes to a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] s);
    lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction
endpackage

// [verilog/capcomp_unit.sv]
`timescale 1ns/1ns
`include "tccp_params.svh"
module capcomp_unit
  import tccp_pkg::*;
#(parameter int TW = 16) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control and value access
  input wire logic [5:0] ctrl,
  input wire logic value_wr,
  input wire logic [TW-1:0] value_wdata,
  input wire logic [TW-1:0] value_wmask,
  output logic [TW-1:0] value_q,
  // Time bases
  input wire logic [TW-1:0] t1_count,
  input wire logic t2_restart,
  input wire logic [9:0] t2_fine,
  // Pin and event
  input wire logic pin_sync,
  output logic pin_out_q,
  output logic pin_oe_q,
  output logic event_q
);
  unit_mode_t mode;
  logic [1:0] variant;
  logic pin_prev_q;
  logic [3:0] edge_cnt_q;
  logic rise, fall, cap_fire, eq_q, hit;
  logic [9:0] duty_q, duty_next;

  // Mode, variant and duty assembly
  assign mode = decode_mode(ctrl[`U_MODE_LO +: 4]);
  assign variant = ctrl[1:0];
  assign duty_next = {value_q[7:0], ctrl[`U_DUTY_LO +: 2]};
  assign rise = pin_sync & ~pin_prev_q;
  assign fall = ~pin_sync & pin_prev_q;
  assign hit = (mode == unit_compare) && (t1_count == value_q) && !eq_q;

  // Capture edge choice: fall, rise, every 4th or 16th rise
  always_comb begin
    case (variant)
      2'h0: cap_fire = fall;
      2'h1: cap_fire = rise;
      2'h2: cap_fire = rise && (edge_cnt_q[1:0] == 2'h3);
      default: cap_fire = rise && (edge_cnt_q == 4'hF);
    endcase
  end

  // Edge history and rise counter
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_prev_q <= 1'b0;
      edge_cnt_q <= 4'h0;
      eq_q <= 1'b0;
    end else begin
      pin_prev_q <= pin_sync;
      eq_q <= (t1_count == value_q);
      if (mode != unit_capture) edge_cnt_q <= 4'h0;
      else if (rise) edge_cnt_q <= edge_cnt_q + 4'h1;
    end
  end

  // Value register; a capture wins over a software write
  always_ff @(posedge clk) begin
    if (rst) value_q <= TW'(`COUNT_RST);
    else if (mode == unit_capture && cap_fire) value_q <= t1_count;
    else if (value_wr) value_q <= (value_q & ~value_wmask) | (value_wdata & value_wmask);
  end

  // Event pulse on capture or match
  always_ff @(posedge clk) begin
    if (rst) event_q <= 1'b0;
    else event_q <= (mode == unit_capture && cap_fire) || hit;
  end

  // Pin drive per mode
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_out_q <= 1'b0;
      pin_oe_q <= 1'b0;
      duty_q <= 10'h000;
    end else begin
      case (mode)
        unit_compare: begin
          pin_oe_q <= !variant[1];
          if (hit && !variant[1]) pin_out_q <= !variant[0];
        end
        unit_pwm: begin
          pin_oe_q <= 1'b1;
          if (t2_restart) begin
            duty_q <= duty_next;
            pin_out_q <= (duty_next != 10'h000);
          end else if (t2_fine >= duty_q) begin
            pin_out_q <= 1'b0;
          end
        end
        default: begin
          pin_oe_q <= 1'b0;
          pin_out_q <= 1'b0;
        end
      endcase
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_capture;
    mode == unit_capture && cap_fire;
  endsequence
  sequence s_restart;
    mode == unit_pwm && t2_restart && duty_next != 10'h000;
  endsequence
  chk_capture_latch: assert property (s_capture |=> value_q == $past(t1_count) && event_q)
    else $error("capture did not latch timer count");
  chk_compare_event: assert property (hit && variant == 2'h0 |=> event_q && pin_out_q)
    else $error("compare match without event or pin high");
  chk_pwm_rise: assert property (s_restart |=> pin_out_q && pin_oe_q)
    else $error("pwm output not high after restart");
  chk_off_quiet: assert property (mode == unit_off |=> !pin_oe_q && !event_q)
    else $error("unit active while off");
endmodule // capcomp_unit

// [verif/pin_partner.sv]
`timescale 1ns/1ns
// Far side: counting pin, capture pins and the PWM loads
module pin_partner (
  // Clock
  input wire logic clk,
  // Pins toward the block
  output logic ext_pin,
  output logic cap_one,
  output logic cap_two,
  // PWM loads
  input wire logic pwm_one,
  input wire logic pwm_two
);
  // Pins rest low between bursts
  initial begin
    ext_pin = 1'b0;
    cap_one = 1'b0;
    cap_two = 1'b0;
  end
  // Burst of counting pulses, 10 clk high and 11 low
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk);
      ext_pin <= 1'b1;
      repeat (10) @(posedge clk);
      ext_pin <= 1'b0;
      repeat (10) @(posedge clk);
    end
  endtask
  // One rising then falling edge on the first capture pin
  task automatic strobe_one();
    @(posedge clk);
    cap_one <= 1'b1;
    repeat (10) @(posedge clk);
    cap_one <= 1'b0;
    repeat (10) @(posedge clk);
  endtask
  // High cycles seen on each load over a window
  task automatic measure(input int len, output int h1, output int h2);
    h1 = 0;
    h2 = 0;
    repeat (len) begin
      @(posedge clk);
      if (pwm_one === 1'b1) h1++;
      if (pwm_two === 1'b1) h2++;
    end
  endtask
endmodule // pin_partner

// [verif/timer_capture_compare_pwm_tb.sv]
`timescale 1ns/1ns
`include "tccp_params.svh"
module timer_capture_compare_pwm_tb;
  logic clk, rst;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb, event_flags;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, external_count_pin, osc_circuit_enable;
  logic unit_one_pin_in, unit_one_pin_out, unit_one_pin_oe;
  logic unit_two_pin_in, unit_two_pin_out, unit_two_pin_oe;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;

  timer_capture_compare_pwm timer_capture_compare_pwm_inst (
    .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .external_count_pin,
    .osc_circuit_enable, .unit_one_pin_in, .unit_one_pin_out, .unit_one_pin_oe,
    .unit_two_pin_in, .unit_two_pin_out, .unit_two_pin_oe, .event_flags);
  pin_partner pin_partner_inst (.clk, .ext_pin(external_count_pin),
    .cap_one(unit_one_pin_in), .cap_two(unit_two_pin_in),
    .pwm_one(unit_one_pin_out), .pwm_two(unit_two_pin_out));

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  // Verdict and end of run
  task automatic tally_and_finish();
    if (miscompares == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Exact comparison
  task automatic chk_eq(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // Comparison within a tolerance
  task automatic chk_near(input string n, input int e, input int t, input logic [31:0] g);
    cmp_count++;
    if ($isunknown(g) || int'(g) > e + t || int'(g) < e - t) begin
      miscompares++;
      $display("wrong value %s expected %0d seen %0d", n, e, g);
    end
  endtask
  // Bus write, both items offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (aw && s_axi_awready === 1'b1) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid === 1'b1) begin
        rr = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask
  // Bus read into rv and rr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        rv = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask

  // Reset values and an unmapped read
  task automatic t_reset();
    rd(`T2_PERIOD_OFS);
    chk_eq("t2_period", 32'h0000_00ff, rv);
    rd(8'h28);
    chk_eq("unmapped_resp", {30'h0, `RESP_SLVERR}, {30'h0, rr});
    wr(8'h28, 32'h0000_0001);
    chk_eq("unmapped_bresp", {30'h0, `RESP_SLVERR}, {30'h0, rr});
  endtask
  // Oscillator enable, load and hold
  task automatic t_hold();
    wr(`T1_CTRL_OFS, 32'h0000_0008);
    chk_eq("osc_en", 32'h1, {31'h0, osc_circuit_enable});
    wr(`T1_COUNT_OFS, 32'h0000_1234);
    repeat (100) @(posedge clk);
    rd(`T1_COUNT_OFS);
    chk_eq("t1_hold", 32'h0000_1234, rv);
  endtask
  // Internal source at each prescale
  task automatic t_prescale();
    for (int p = 0; p < 4; p++) begin
      wr(`T1_COUNT_OFS, 32'h0);
      wr(`T1_CTRL_OFS, 32'(p * 16 + 1));
      repeat (800) @(posedge clk);
      wr(`T1_CTRL_OFS, 32'h0);
      rd(`T1_COUNT_OFS);
      chk_near("t1_rate", 200 >> p, 3, rv);
    end
  endtask
  // Pin source, unsynchronised then synchronised
  task automatic t_external();
    for (int s = 0; s < 2; s++) begin
      wr(`T1_COUNT_OFS, 32'h0);
      wr(`T1_CTRL_OFS, 32'(s * 4 + 3));
      pin_partner_inst.pulses(20);
      wr(`T1_CTRL_OFS, 32'h0);
      rd(`T1_COUNT_OFS);
      chk_eq("t1_ext", 32'h0000_0014, rv);
    end
  endtask
  // Wrap from all ones, flag set and cleared
  task automatic t_overflow();
    wr(`FLAGS_OFS, 32'hf);
    wr(`T1_COUNT_OFS, 32'h0000_fffe);
    wr(`T1_CTRL_OFS, 32'h1);
    repeat (20) @(posedge clk);
    wr(`T1_CTRL_OFS, 32'h0);
    chk_eq("ovf_flag", 32'h1, {28'h0, event_flags});
    rd(`T1_COUNT_OFS);
    chk_near("t1_wrap", 4, 2, rv);
    wr(`FLAGS_OFS, 32'h1);
    chk_eq("ovf_clear", 32'h0, {28'h0, event_flags});
  endtask
  // Second timer rate at each prescale, period access
  task automatic t_second();
    int ex [4] = '{160, 40, 10, 10};
    wr(`T2_PERIOD_OFS, 32'h0000_005a);
    rd(`T2_PERIOD_OFS);
    chk_eq("t2_period_rw", 32'h0000_005a, rv);
    wr(`T2_PERIOD_OFS, 32'h0000_00ff);
    for (int p = 0; p < 4; p++) begin
      wr(`T2_COUNT_OFS, 32'h0);
      wr(`T2_CTRL_OFS, 32'(p + 4));
      repeat (640) @(posedge clk);
      wr(`T2_CTRL_OFS, 32'h0);
      rd(`T2_COUNT_OFS);
      chk_near("t2_rate", ex[p], 3, rv);
    end
  endtask
  // Divide by sixteen postscale on period 9
  task automatic t_postscale();
    wr(`T2_PERIOD_OFS, 32'h9);
    wr(`T2_COUNT_OFS, 32'h0);
    wr(`FLAGS_OFS, 32'hf);
    wr(`T2_CTRL_OFS, 32'h0000_007c);
    repeat (560) @(posedge clk);
    chk_eq("post_early", 32'h0, {28'h0, event_flags});
    repeat (160) @(posedge clk);
    chk_eq("post_event", 32'h2, {28'h0, event_flags});
    wr(`T2_CTRL_OFS, 32'h0);
  endtask
  // Compare with pin variant and event-only variant
  task automatic t_compare();
    wr(`U1_VALUE_OFS, 32'h0000_0028);
    wr(`U2_VALUE_OFS, 32'h0000_0028);
    wr(`T1_COUNT_OFS, 32'h0);
    wr(`FLAGS_OFS, 32'hf);
    wr(`U1_CTRL_OFS, 32'h8);
    wr(`U2_CTRL_OFS, 32'hb);
    chk_eq("cmp_idle", 32'h0, {28'h0, event_flags});
    wr(`T1_CTRL_OFS, 32'h1);
    repeat (200) @(posedge clk);
    chk_eq("cmp_pins", 32'h6, {unit_one_pin_out, unit_one_pin_oe, unit_two_pin_oe});
    chk_eq("cmp_flags", 32'hc, {28'h0, event_flags});
    wr(`T1_CTRL_OFS, 32'h0);
  endtask
  // Capture on a rising pin edge, then on a falling pin edge
  task automatic t_capture();
    wr(`T1_COUNT_OFS, 32'h0000_0123);
    wr(`U1_CTRL_OFS, 32'h5);
    pin_partner_inst.strobe_one();
    rd(`U1_VALUE_OFS);
    chk_eq("cap_value", 32'h0000_0123, rv);
    wr(`T1_COUNT_OFS, 32'h0000_0456);
    wr(`U1_CTRL_OFS, 32'h4);
    pin_partner_inst.strobe_one();
    rd(`U1_VALUE_OFS);
    chk_eq("cap_fall", 32'h0000_0456, rv);
  endtask
  // PWM duty 20 and 21 of 40 on both units
  task automatic t_pwm();
    int h1, h2;
    wr(`T2_PERIOD_OFS, 32'h9);
    wr(`T2_CTRL_OFS, 32'h4);
    wr(`U1_VALUE_OFS, 32'h5);
    wr(`U2_VALUE_OFS, 32'h5);
    wr(`U1_CTRL_OFS, 32'hc);
    wr(`U2_CTRL_OFS, 32'h0000_001c);
    repeat (80) @(posedge clk);
    pin_partner_inst.measure(400, h1, h2);
    chk_near("pwm_one", 200, 4, h1);
    chk_near("pwm_two", 210, 4, h2);
    chk_eq("pwm_oe", 32'h3, {unit_one_pin_oe, unit_two_pin_oe});
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_reset();
    t_hold();
    t_prescale();
    t_external();
    t_overflow();
    t_second();
    t_postscale();
    t_compare();
    t_capture();
    t_pwm();
    tally_and_finish();
  end
endmodule // timer_capture_compare_pwm_tb
